// ---- core/cabt_ahb_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
// AHB-Lite slave holding the two mode registers and the calibration point
module cabt_ahb_regs (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] statusWord,
    output logic [31:0] hrdata,
    output logic valueWrite,
    cabt_cfg_if.slave cfg
);
    logic [7:0] value_q, value_d; // Value register
    logic [7:0] disable_q, disable_d; // Disable register
    logic calPt_q, calPt_d; // Calibration point
    logic wrPend_q, wrPend_d; // Write data phase pending
    logic [3:0] wrAddr_q, wrAddr_d; // Latched write offset
    logic [31:0] rdata_q, rdata_d; // Read data
    logic valueWr_q, valueWr_d; // Value written pulse

    // Address phase accepted
    function automatic logic cabt_take(input logic sel, input logic [1:0] tr, input logic rdy);
        cabt_take = sel && rdy && tr == cabt_pkg::CABT_HTRANS_NONSEQ;
    endfunction : cabt_take

    // Next state of registers and bus phase
    always_comb begin
        value_d = value_q;
        disable_d = disable_q;
        calPt_d = calPt_q;
        wrPend_d = 1'b0;
        wrAddr_d = wrAddr_q;
        rdata_d = rdata_q;
        valueWr_d = 1'b0;
        // Data phase of a write: store word
        if (wrPend_q) begin
            case (wrAddr_q)
                cabt_pkg::CABT_OFS_VALUE: begin
                    value_d = hwdata[7:0];
                    valueWr_d = 1'b1;
                end
                cabt_pkg::CABT_OFS_DISABLE: begin
                    disable_d = hwdata[7:0];
                end
                cabt_pkg::CABT_OFS_CALPT: begin
                    calPt_d = hwdata[0];
                end
                default: begin
                    // Unmapped or read-only: ignored
                end
            endcase
        end
        // Address phase
        if (cabt_take(hsel, htrans, hready)) begin
            if (hwrite) begin
                wrPend_d = 1'b1;
                wrAddr_d = haddr[3:0];
            end else begin
                case (haddr[3:0])
                    cabt_pkg::CABT_OFS_VALUE: rdata_d = {24'h000000, value_d};
                    cabt_pkg::CABT_OFS_DISABLE: rdata_d = {24'h000000, disable_d};
                    cabt_pkg::CABT_OFS_STATUS: rdata_d = statusWord;
                    cabt_pkg::CABT_OFS_CALPT: rdata_d = {31'h00000000, calPt_d};
                    default: rdata_d = 32'h00000000;
                endcase
            end
        end
    end

    // Register stage
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            value_q <= cabt_pkg::CABT_VALUE_RST;
            disable_q <= cabt_pkg::CABT_DISABLE_RST;
            calPt_q <= cabt_pkg::CABT_CALPT_RST;
            wrPend_q <= 1'b0;
            wrAddr_q <= 4'h0;
            rdata_q <= 32'h00000000;
            valueWr_q <= 1'b0;
        end else begin
            value_q <= value_d;
            disable_q <= disable_d;
            calPt_q <= calPt_d;
            wrPend_q <= wrPend_d;
            wrAddr_q <= wrAddr_d;
            rdata_q <= rdata_d;
            valueWr_q <= valueWr_d;
        end
    end

    assign hrdata = rdata_q;
    assign valueWrite = valueWr_q;
    assign cfg.valueReg = value_q;
    assign cfg.disableReg = disable_q;
    assign cfg.calPoint = calPt_q;
endmodule : cabt_ahb_regs
`default_nettype wire

// ---- core/cabt_ca_term_ctrl.sv ----
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Command-bus termination control: register decode to per-group enables
module cabt_ca_term_ctrl (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic termCaOn,
    output logic termCkOn,
    output logic termCsOn,
    output logic [2:0] termCode,
    output logic termUpdating,
    output logic badCombo
);
    typedef enum {CABT_ST_STABLE, CABT_ST_UPDATE} cabt_upd_e;

    cabt_cfg_if cfg ();
    logic [31:0] statusWord; // Read-back of live state
    logic valueWrite; // Pulse after value register write
    logic [31:0] rdata; // Read data from slave
    logic [2:0] code; // Current value field

    logic caOn_q, caOn_d; // CA group termination
    logic ckOn_q, ckOn_d; // Clock pair termination
    logic csOn_q, csOn_d; // Chip-select termination
    logic [2:0] code_q, code_d; // Applied value code
    logic bad_q, bad_d; // Forbidden calibration combination
    cabt_upd_e st_q, st_d; // Update wait state
    logic [3:0] cnt_q, cnt_d; // Update wait counter
    logic updOn_q, updOn_d; // Registered update flag for the output pin

    // Valid termination code test
    function automatic logic cabt_code_ok(input logic [2:0] c);
        cabt_code_ok = c != cabt_pkg::CABT_CODE_OFF && c != cabt_pkg::CABT_CODE_BAD;
    endfunction : cabt_code_ok

    cabt_ahb_regs u_regs (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .statusWord(statusWord),
        .hrdata(rdata),
        .valueWrite(valueWrite),
        .cfg(cfg)
    );

    assign code = cfg.valueReg[cabt_pkg::CABT_VAL_MSB:cabt_pkg::CABT_VAL_LSB];
    // Status: bits 0-2 group states, 3 updating, 4 bad combo, 10:8 code
    assign statusWord = {21'h000000, code_q, 3'h0, bad_q, st_q == CABT_ST_UPDATE, csOn_q, ckOn_q, caOn_q};

    // Next termination state, from mode registers only
    always_comb begin
        code_d = cabt_code_ok(code) ? code : cabt_pkg::CABT_CODE_OFF;
        caOn_d = cabt_code_ok(code) && !cfg.disableReg[cabt_pkg::CABT_DIS_CA];
        ckOn_d = cabt_code_ok(code) && !cfg.disableReg[cabt_pkg::CABT_DIS_CK];
        csOn_d = cabt_code_ok(code) && !cfg.disableReg[cabt_pkg::CABT_DIS_CS];
        // Only 120 and 60 allowed at the 0.6 point
        bad_d = cfg.calPoint && cabt_code_ok(code) &&
            code != cabt_pkg::CABT_CODE_120 && code != cabt_pkg::CABT_CODE_60;
    end

    // Update wait after a value write; calibration stays valid
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
            CABT_ST_STABLE: begin
                if (valueWrite) begin
                    st_d = CABT_ST_UPDATE;
                    cnt_d = cabt_pkg::CABT_UPD_CYC;
                end
            end
            CABT_ST_UPDATE: begin
                if (valueWrite) begin
                    cnt_d = cabt_pkg::CABT_UPD_CYC;
                end else if (cnt_q <= 4'h1) begin
                    st_d = CABT_ST_STABLE;
                    cnt_d = 4'h0;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            default: begin
                st_d = CABT_ST_STABLE;
                cnt_d = 4'h0;
            end
        endcase
        // Flag follows the next state so the pin comes from a flop
        updOn_d = st_d == CABT_ST_UPDATE;
    end

    // Register stage
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            caOn_q <= 1'b0;
            ckOn_q <= 1'b0;
            csOn_q <= 1'b0;
            code_q <= cabt_pkg::CABT_CODE_OFF;
            bad_q <= 1'b0;
            st_q <= CABT_ST_STABLE;
            cnt_q <= 4'h0;
            updOn_q <= 1'b0;
        end else begin
            caOn_q <= caOn_d;
            ckOn_q <= ckOn_d;
            csOn_q <= csOn_d;
            code_q <= code_d;
            bad_q <= bad_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            updOn_q <= updOn_d;
        end
    end

    assign hrdata = rdata;
    assign hreadyout = 1'b1; // Zero wait states
    assign hresp = 1'b0; // Always OKAY
    assign termCaOn = caOn_q;
    assign termCkOn = ckOn_q;
    assign termCsOn = csOn_q;
    assign termCode = code_q;
    assign termUpdating = updOn_q;
    assign badCombo = bad_q;
endmodule : cabt_ca_term_ctrl
`default_nettype wire

// ---- core/cabt_cfg_if.sv ----
`timescale 1ns/10ps
`default_nettype none
// Register contents handed from the bus slave to the decode logic
interface cabt_cfg_if;
    logic [7:0] valueReg; // Termination configuration register
    logic [7:0] disableReg; // Group disable register
    logic calPoint; // Pull-up point: 0 = 0.5, 1 = 0.6
    modport slave (output valueReg, output disableReg, output calPoint);
    modport user (input valueReg, input disableReg, input calPoint);
endinterface : cabt_cfg_if
`default_nettype wire

// ---- core/cabt_pkg.sv ----
// Notes on behaviour
// - Bits 6:4 of config register give value
// - Termination disabled after reset until written
// - Codes 001..110 select 240 down to 40 ohm
// - Disable bits 5/3/4 gate CA/clock/chip-select
// - Termination covers clock pair, chip-select, CA5:0
// - Enable comes from registers only, no pin
// - Value change keeps calibration valid
package cabt_pkg;
    // Register byte offsets on the bus
    localparam logic [3:0] CABT_OFS_VALUE = 4'h0;
    localparam logic [3:0] CABT_OFS_DISABLE = 4'h4;
    localparam logic [3:0] CABT_OFS_STATUS = 4'h8;
    localparam logic [3:0] CABT_OFS_CALPT = 4'hC;
    // Field positions
    localparam int CABT_VAL_LSB = 4;
    localparam int CABT_VAL_MSB = 6;
    localparam int CABT_DIS_CK = 3;
    localparam int CABT_DIS_CS = 4;
    localparam int CABT_DIS_CA = 5;
    // Reset values
    localparam logic [7:0] CABT_VALUE_RST = 8'h00;
    localparam logic [7:0] CABT_DISABLE_RST = 8'h00;
    localparam logic CABT_CALPT_RST = 1'b0;
    // Value codes
    localparam logic [2:0] CABT_CODE_OFF = 3'h0;
    localparam logic [2:0] CABT_CODE_240 = 3'h1;
    localparam logic [2:0] CABT_CODE_120 = 3'h2;
    localparam logic [2:0] CABT_CODE_80 = 3'h3;
    localparam logic [2:0] CABT_CODE_60 = 3'h4;
    localparam logic [2:0] CABT_CODE_48 = 3'h5;
    localparam logic [2:0] CABT_CODE_40 = 3'h6;
    localparam logic [2:0] CABT_CODE_BAD = 3'h7;
    // Update time, ns, and derived cycles at 8 ns clock
    localparam int CABT_CLK_NS = 8;
    localparam int CABT_UPD_NS = 16;
    localparam int CABT_UPD_CYC_I = (CABT_UPD_NS + CABT_CLK_NS - 1) / CABT_CLK_NS;
    localparam logic [3:0] CABT_UPD_CYC = 4'(CABT_UPD_CYC_I < 1 ? 1 : CABT_UPD_CYC_I);
    // Bus transfer codes
    localparam logic [1:0] CABT_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] CABT_HSIZE_WORD = 3'h2;
endpackage : cabt_pkg

// ---- sim/cabt_ahb_host.sv ----
`timescale 1ns/10ps
`default_nettype none
// Controller side: single-word transfers to the mode registers
module cabt_ahb_host (
    input wire logic clk_sys,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // Idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // One transfer; waits on hready with a bound, ok low on a hang
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic ok);
        int n;
        ok = 1'b1;
        hsel <= 1'b1;
        htrans <= cabt_pkg::CABT_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        hsize <= cabt_pkg::CABT_HSIZE_WORD;
        hwdata <= ~hwdata; // Stale data never repeats
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hready !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hready !== 1'b1 && n < 100);
        r = hrdata;
        ok = n < 100;
    endtask : xfer
endmodule : cabt_ahb_host
`default_nettype wire

// ---- sim/cabt_ca_term_ctrl_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the termination control block
module cabt_ca_term_ctrl_tb_top;
    logic clk_sys = 1'b0; // 125 MHz clock
    logic rst_n = 1'b0; // Active low reset
    logic hsel, hwrite, hreadyout, hresp, caOn, ckOn, csOn, upd, bad, en;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [31:0] exSt; // Expected status word from the rules
    logic [1:0] htrans;
    logic [2:0] hsize, code, dis, tc;
    int errCount = 0;
    int totalChecks = 0;
    // Clock generator
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    // Bus master in the controller's place
    cabt_ahb_host i_host (.clk_sys(clk_sys), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    cabt_ca_term_ctrl i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .termCaOn(caOn), .termCkOn(ckOn),
        .termCsOn(csOn), .termCode(tc), .termUpdating(upd), .badCombo(bad));
    // Compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errCount++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Print counts and verdict, then stop
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    // Bus access; a hang ends the run
    task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] d);
        logic ok;
        i_host.xfer(wr, a, d, rd, ok);
        if (!ok) begin
            errCount++;
            give_verdict();
        end
    endtask : acc
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        // Reset values of the four offsets, plus 0x10, which aliases offset 0
        for (int a = 0; a < 20; a += 4) begin
            acc(1'b0, 32'(a), 32'h0);
            chk(rd, 32'h0);
        end
        $display("reset test done");
        // Every code, every disable pattern, both pull-up points
        for (int i = 0; i < 16; i++) begin
            code = 3'(i);
            dis = 3'(i + 1);
            en = code != 3'h0 && code != 3'h7;
            acc(1'b1, 32'hC, {31'h0, i[3]});
            acc(1'b1, 32'h4, {26'h3FFFFFF, dis, 3'h0});
            acc(1'b1, 32'h0, {25'h1FFFFFF, code, 4'hF});
            repeat (2) @(posedge clk_sys);
            chk(32'(upd), 32'h1);
            repeat (2) @(posedge clk_sys);
            acc(1'b0, 32'h0, 32'h0);
            chk(rd, {24'h0, 1'b1, code, 4'hF});
            exSt = {21'h0, en ? code : 3'h0, 3'h0, en && i[3] && code != 3'h2 && code != 3'h4,
                1'b0, en && !dis[1], en && !dis[0], en && !dis[2]};
            acc(1'b0, 32'h8, 32'h0);
            chk(rd, exSt);
            chk(32'({tc, 3'h0, bad, upd, csOn, ckOn, caOn}), exSt);
        end
        $display("decode test done");
        // Reset in mid-run with termination on
        acc(1'b1, 32'h0, 32'h20);
        repeat (4) @(posedge clk_sys);
        chk(32'({tc, caOn, ckOn, csOn}), 32'h17);
        rst_n <= 1'b0;
        @(posedge clk_sys);
        chk(32'({tc, caOn, ckOn, csOn, upd}), 32'h0);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        acc(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h0);
        chk(32'({hresp, hreadyout}), 32'h1);
        $display("second reset test done");
        give_verdict();
    end
endmodule : cabt_ca_term_ctrl_tb_top
// Checker on the top's ports
bind cabt_ca_term_ctrl cabt_term_monitor i_mon (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .termCaOn(termCaOn), .termCkOn(termCkOn),
    .termCsOn(termCsOn), .termCode(termCode), .termUpdating(termUpdating), .badCombo(badCombo));
`default_nettype wire

// ---- sim/cabt_term_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
// Port checker for the termination control top
module cabt_term_monitor (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic termCaOn,
    input wire logic termCkOn,
    input wire logic termCsOn,
    input wire logic [2:0] termCode,
    input wire logic termUpdating,
    input wire logic badCombo
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Value register write taken on the bus
    wire logic valWr = hsel && hwrite && htrans == 2'h2 && haddr[3:0] == 4'h0;
    property p_allOff; termCode == 3'h0 |-> !termCaOn && !termCkOn && !termCsOn; endproperty
    a_allOff: assert property (p_allOff) else $error("group on while code off");
    property p_no7; termCode != 3'h7; endproperty
    a_no7: assert property (p_no7) else $error("unsupported code applied");
    property p_codeHold; !termUpdating |-> $stable(termCode); endproperty
    a_codeHold: assert property (p_codeHold) else $error("code moved outside update");
    property p_updLen; $rose(termUpdating) |=> termUpdating; endproperty
    a_updLen: assert property (p_updLen) else $error("update wait too short");
    property p_updCause; valWr |-> ##[1:4] termUpdating; endproperty
    a_updCause: assert property (p_updCause) else $error("no update after value write");
    property p_noSpur; $rose(termUpdating) |-> $past(valWr, 2) || $past(valWr, 3) || $past(valWr, 4); endproperty
    a_noSpur: assert property (p_noSpur) else $error("update without value write");
    property p_bad; badCombo |-> termCode != 3'h0 && termCode != 3'h2 && termCode != 3'h4; endproperty
    a_bad: assert property (p_bad) else $error("bad combination flagged wrongly");
    property p_rst; $rose(rst_n) |-> termCode == 3'h0 && !termCaOn && !termCkOn && !termCsOn; endproperty
    a_rst: assert property (p_rst) else $error("termination on after reset");
    // Main scenarios reached
    c_allOn: cover property (termCaOn && termCkOn && termCsOn);
    c_bad: cover property (badCombo);
    c_upd: cover property ($fell(termUpdating));
endmodule : cabt_term_monitor
`default_nettype wire
